// ### src/spos_object_store.sv
// servo parameter object store: object write/read port, attribute
// classes, direction mapping and autotuning mode decode
// assumes all inputs synchronous to ref_clk; reset_n is control power
//
// What this block does
// - objects 3000..3999 hex carry the drive parameters of the same digits.
// - class B objects may be written in motion; they apply only once motor and command are idle.
// - class C writes stay pending until power restart or a config command.
// - class D writes are taken only in the preoperational state.
// - class R writes apply only at power restart, never on config command.
// - the direction setting applies alike to position, speed and force.
// - direction 0 turns positive commands into encoder-negative motion.
// - the prohibition inputs follow the commanded sense, not the encoder.
// - autotuning mode holds 0..6, resets to 1, and is a class B object.
// - autotuning codes decode to off, stable, position, unbalanced, etc.
`timescale 1ns/1ps
module spos_object_store
  import spos_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic objWrEn,
  input wire logic objRdEn,
  input wire logic [15:0] objIndex,
  input wire logic [DATA_W-1:0] objWrData,
  input wire logic preoperationalState,
  input wire logic configCmd,
  input wire logic ctrlPowerRestart,
  input wire logic motorMoving,
  input wire logic commandActive,
  input wire logic cmdPos,
  input wire logic cmdNeg,
  input wire logic posProhibit,
  input wire logic negProhibit,
  output logic objWrAck_r,
  output logic objWrErr_r,
  output logic objRdValid_r,
  output logic objRdErr_r,
  output logic [DATA_W-1:0] objRdData_r,
  output logic movementDir_r,
  output logic dirPending_r,
  output logic [2:0] tuneMode_r,
  output logic tunePending_r,
  output logic tuneOff_r,
  output logic tuneStable_r,
  output logic tunePosition_r,
  output logic tuneUnbal_r,
  output logic tuneFriction_r,
  output logic tuneCustom_r,
  output logic encUp_r,
  output logic encDown_r,
  output logic posBlocked_r,
  output logic negBlocked_r
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  function automatic spos_class_t attrClass(input logic [15:0] idx);
    if (idx == SPOS_IDX_MOVE_DIR) begin
      attrClass = SPOS_CLS_C;
    end else if (idx == SPOS_IDX_TUNE_MODE) begin
      attrClass = SPOS_CLS_B;
    end else begin
      attrClass = SPOS_CLS_A;
    end
  endfunction : attrClass

  function automatic logic [15:0] maxValue(input logic [15:0] idx);
    if (idx == SPOS_IDX_MOVE_DIR) begin
      maxValue = SPOS_DIR_MAX;
    end else if (idx == SPOS_IDX_TUNE_MODE) begin
      maxValue = SPOS_TUNE_MAX;
    end else begin
      maxValue = SPOS_ANY_MAX;
    end
  endfunction : maxValue

  function automatic logic inBlock(input logic [15:0] idx);
    inBlock = (idx[15:12] == SPOS_IDX_BLOCK) && (idx >= SPOS_IDX_LOW)
      && (idx <= SPOS_IDX_HIGH);
  endfunction : inBlock

  // class C takes either event, class R only the power restart
  function automatic logic applyNow(input spos_class_t cls,
                                    input logic cfg,
                                    input logic pwr);
    case (cls)
      SPOS_CLS_C: applyNow = cfg | pwr;
      SPOS_CLS_R: applyNow = pwr;
      default: applyNow = 1'b0;
    endcase
  endfunction : applyNow

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  wire spos_class_t wrClass = attrClass(objIndex);
  wire idxOk = inBlock(objIndex);
  wire [15:0] wrMax = maxValue(objIndex);
  wire valueOk = objWrData <= wrMax;
  wire classD = wrClass == SPOS_CLS_D;
  wire classOk = ~classD | preoperationalState;
  wire wrTake = objWrEn & idxOk & valueOk & classOk;
  wire wrRefuse = objWrEn & ~wrTake;
  wire isDir = objIndex == SPOS_IDX_MOVE_DIR;
  wire isTune = objIndex == SPOS_IDX_TUNE_MODE;
  wire dirWr = wrTake & isDir;
  wire tuneWr = wrTake & isTune;
  wire ramWr = wrTake & ~isDir & ~isTune;

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  // a read beside a write is dropped; the write port has priority
  wire rdTake = objRdEn & ~objWrEn;
  wire ramRd = rdTake & idxOk;
  wire rdBadNxt = rdTake & ~idxOk;
  wire rdDirNxt = rdTake & isDir;
  wire rdTuneNxt = rdTake & isTune;

  // ------------------------------------------------------------
  // apply events
  // ------------------------------------------------------------
  // restart comes in as a pulse since the flops lose state at reset
  wire dirApply = applyNow(SPOS_CLS_C, configCmd, ctrlPowerRestart);
  wire busy = motorMoving | commandActive;

  // ------------------------------------------------------------
  // generic parameter store
  // ------------------------------------------------------------
  logic [DATA_W-1:0] ramData;

  spos_param_ram #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_ram (
    .ref_clk(ref_clk),
    .wrEn(ramWr),
    .rdEn(ramRd),
    .addr(objIndex[ADDR_W-1:0]),
    .wrData(objWrData),
    .rdData(ramData)
  );

  // ------------------------------------------------------------
  // movement direction object (class C)
  // ------------------------------------------------------------
  logic dirStored_r;
  logic dirStored_nxt;
  logic movementDir_nxt;
  logic dirPending_nxt;

  assign dirStored_nxt = dirWr ? objWrData[0] : dirStored_r;
  // a write landing with the apply event stays pending (set wins)
  assign movementDir_nxt = dirApply ? dirStored_r : movementDir_r;
  assign dirPending_nxt = dirWr ? 1'b1 : (dirApply ? 1'b0 : dirPending_r);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dirStored_r <= SPOS_DIR_RESET[0];
      movementDir_r <= SPOS_DIR_RESET[0];
      dirPending_r <= 1'b0;
    end else begin
      dirStored_r <= dirStored_nxt;
      movementDir_r <= movementDir_nxt;
      dirPending_r <= dirPending_nxt;
    end
  end

  // ------------------------------------------------------------
  // autotuning mode object (class B)
  // ------------------------------------------------------------
  // held back until standstill so the gain never jumps mid-move
  logic [2:0] tuneStored_r;
  logic [2:0] tuneStored_nxt;
  logic [2:0] tuneMode_nxt;
  logic tunePending_nxt;
  wire tuneApply = tunePending_r & ~busy;

  assign tuneStored_nxt = tuneWr ? objWrData[2:0] : tuneStored_r;
  assign tuneMode_nxt = tuneApply ? tuneStored_r : tuneMode_r;
  assign tunePending_nxt = tuneWr ? 1'b1 :
    (tuneApply ? 1'b0 : tunePending_r);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tuneStored_r <= SPOS_TUNE_RESET[2:0];
      tuneMode_r <= SPOS_TUNE_RESET[2:0];
      tunePending_r <= 1'b0;
    end else begin
      tuneStored_r <= tuneStored_nxt;
      tuneMode_r <= tuneMode_nxt;
      tunePending_r <= tunePending_nxt;
    end
  end

  // ------------------------------------------------------------
  // autotuning decode
  // ------------------------------------------------------------
  // code 5 is reserved and enables none of the modes
  wire [15:0] tuneWide = {13'h0000, tuneMode_nxt};
  wire tuneOffNxt = tuneWide == SPOS_TUNE_OFF;
  wire tuneStableNxt = tuneWide == SPOS_TUNE_STABLE;
  wire tunePositionNxt = tuneWide == SPOS_TUNE_POSITION;
  wire tuneUnbalNxt = tuneWide == SPOS_TUNE_UNBAL;
  wire tuneFrictionNxt = tuneWide == SPOS_TUNE_FRICTION;
  wire tuneCustomNxt = tuneWide == SPOS_TUNE_CUSTOM;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tuneOff_r <= 1'b0;
      tuneStable_r <= 1'b1;
      tunePosition_r <= 1'b0;
      tuneUnbal_r <= 1'b0;
      tuneFriction_r <= 1'b0;
      tuneCustom_r <= 1'b0;
    end else begin
      tuneOff_r <= tuneOffNxt;
      tuneStable_r <= tuneStableNxt;
      tunePosition_r <= tunePositionNxt;
      tuneUnbal_r <= tuneUnbalNxt;
      tuneFriction_r <= tuneFrictionNxt;
      tuneCustom_r <= tuneCustomNxt;
    end
  end

  // ------------------------------------------------------------
  // write answer
  // ------------------------------------------------------------
  // exactly one answer per write, ack or refusal
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      objWrAck_r <= 1'b0;
      objWrErr_r <= 1'b0;
    end else begin
      objWrAck_r <= wrTake;
      objWrErr_r <= wrRefuse;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // two-stage: ram register, then output register
  logic rdStage_r;
  logic rdBad_r;
  logic rdDir_r;
  logic rdTune_r;
  // the pending word is read back, not the one in force
  wire [DATA_W-1:0] dirWord = DATA_W'(dirStored_r);
  wire [DATA_W-1:0] tuneWord = DATA_W'(tuneStored_r);
  wire [DATA_W-1:0] ramWord = rdBad_r ? '0 : ramData;
  wire [DATA_W-1:0] rdMux = rdDir_r ? dirWord :
    (rdTune_r ? tuneWord : ramWord);
  wire rdValidNxt = rdStage_r & ~rdBad_r;
  wire rdErrNxt = rdStage_r & rdBad_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdStage_r <= 1'b0;
      rdBad_r <= 1'b0;
      rdDir_r <= 1'b0;
      rdTune_r <= 1'b0;
      objRdValid_r <= 1'b0;
      objRdErr_r <= 1'b0;
      objRdData_r <= '0;
    end else begin
      rdStage_r <= rdTake;
      rdBad_r <= rdBadNxt;
      rdDir_r <= rdDirNxt;
      rdTune_r <= rdTuneNxt;
      objRdValid_r <= rdValidNxt;
      objRdErr_r <= rdErrNxt;
      if (rdStage_r) begin
        objRdData_r <= rdMux;
      end
    end
  end

  // ------------------------------------------------------------
  // direction mapping
  // ------------------------------------------------------------
  spos_dir_map u_dir (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .dirSel(movementDir_r),
    .cmdPos(cmdPos),
    .cmdNeg(cmdNeg),
    .posProhibit(posProhibit),
    .negProhibit(negProhibit),
    .encUp_r(encUp_r),
    .encDown_r(encDown_r),
    .posBlocked_r(posBlocked_r),
    .negBlocked_r(negBlocked_r)
  );

endmodule : spos_object_store

// ### src/spos_pkg.sv
// constants for the servo parameter object store
// assumes a single 20 MHz clock domain and a synchronous object port
package spos_pkg;

  // ------------------------------------------------------------
  // object index map
  // ------------------------------------------------------------
  localparam logic [15:0] SPOS_IDX_LOW = 16'h3000;
  localparam logic [15:0] SPOS_IDX_HIGH = 16'h3999;
  localparam logic [15:0] SPOS_IDX_MOVE_DIR = 16'h3000;
  localparam logic [15:0] SPOS_IDX_TUNE_MODE = 16'h3002;
  localparam logic [3:0] SPOS_IDX_BLOCK = 4'h3;

  // ------------------------------------------------------------
  // reset values and setting ranges
  // ------------------------------------------------------------
  localparam logic [15:0] SPOS_DIR_RESET = 16'h0001;
  localparam logic [15:0] SPOS_DIR_MAX = 16'h0001;
  localparam logic [15:0] SPOS_TUNE_RESET = 16'h0001;
  localparam logic [15:0] SPOS_TUNE_MAX = 16'h0006;
  localparam logic [15:0] SPOS_ANY_MAX = 16'hffff;

  // ------------------------------------------------------------
  // autotuning mode codes
  // ------------------------------------------------------------
  localparam logic [15:0] SPOS_TUNE_OFF = 16'h0000;
  localparam logic [15:0] SPOS_TUNE_STABLE = 16'h0001;
  localparam logic [15:0] SPOS_TUNE_POSITION = 16'h0002;
  localparam logic [15:0] SPOS_TUNE_UNBAL = 16'h0003;
  localparam logic [15:0] SPOS_TUNE_FRICTION = 16'h0004;
  localparam logic [15:0] SPOS_TUNE_RSVD = 16'h0005;
  localparam logic [15:0] SPOS_TUNE_CUSTOM = 16'h0006;

  // ------------------------------------------------------------
  // data attribute classes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SPOS_CLS_A,
    SPOS_CLS_B,
    SPOS_CLS_C,
    SPOS_CLS_D,
    SPOS_CLS_R
  } spos_class_t;

endpackage : spos_pkg

// ### src/spos_param_ram.sv
// single-port word store for the generic parameter objects
// assumes one write or one read per cycle; read data is registered
`timescale 1ns/1ps
module spos_param_ram #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  output logic [DATA_W-1:0] rdData
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // no reset: contents are undefined until written
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
    if (rdEn) begin
      rdData <= mem[addr];
    end
  end

endmodule : spos_param_ram

// ### src/spos_dir_map.sv
// maps logical motion commands onto physical encoder directions
// assumes command and prohibition inputs are synchronous levels
`timescale 1ns/1ps
module spos_dir_map (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic dirSel,
  input wire logic cmdPos,
  input wire logic cmdNeg,
  input wire logic posProhibit,
  input wire logic negProhibit,
  output logic encUp_r,
  output logic encDown_r,
  output logic posBlocked_r,
  output logic negBlocked_r
);

  // ------------------------------------------------------------
  // gating and mapping
  // ------------------------------------------------------------
  // prohibition follows the commanded sense, not the encoder sense
  wire posGo = cmdPos & ~cmdNeg & ~posProhibit;
  wire negGo = cmdNeg & ~cmdPos & ~negProhibit;
  // one selector for position, speed and force commands alike
  wire upNxt = dirSel ? posGo : negGo;
  wire downNxt = dirSel ? negGo : posGo;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      encUp_r <= 1'b0;
      encDown_r <= 1'b0;
      posBlocked_r <= 1'b0;
      negBlocked_r <= 1'b0;
    end else begin
      encUp_r <= upNxt;
      encDown_r <= downNxt;
      posBlocked_r <= cmdPos & posProhibit;
      negBlocked_r <= cmdNeg & negProhibit;
    end
  end

endmodule : spos_dir_map

// ### testbench/spos_sva.sv
// assertions on the object store ports
// assumes a bind into the store and one clock domain
`timescale 1ns/1ps
module spos_sva
  import spos_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic objWrEn,
  input wire logic objRdEn,
  input wire logic [15:0] objIndex,
  input wire logic [DATA_W-1:0] objWrData,
  input wire logic configCmd,
  input wire logic ctrlPowerRestart,
  input wire logic motorMoving,
  input wire logic commandActive,
  input wire logic cmdPos,
  input wire logic cmdNeg,
  input wire logic posProhibit,
  input wire logic negProhibit,
  input wire logic objWrAck_r,
  input wire logic objWrErr_r,
  input wire logic objRdValid_r,
  input wire logic objRdErr_r,
  input wire logic [DATA_W-1:0] objRdData_r,
  input wire logic movementDir_r,
  input wire logic [2:0] tuneMode_r,
  input wire logic encUp_r,
  input wire logic encDown_r,
  input wire logic posBlocked_r
);
  // --------
  // port properties
  // --------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic posGo = cmdPos & ~cmdNeg & ~posProhibit;
  wire logic negGo = cmdNeg & ~cmdPos & ~negProhibit;
  wire logic [1:0] encExp = movementDir_r ? {posGo, negGo} : {negGo, posGo};
  wire logic posHit = cmdPos & ~cmdNeg & posProhibit;
  wire logic still = ~motorMoving & ~commandActive;
  wire logic applyEv = configCmd | ctrlPowerRestart;
  wire logic idxBad = objIndex < SPOS_IDX_LOW || objIndex > SPOS_IDX_HIGH;
  wire logic dirBad = objIndex == SPOS_IDX_MOVE_DIR && objWrData > 16'h0001;
  wire logic tuneBad = objIndex == SPOS_IDX_TUNE_MODE && objWrData > 16'h0006;
  a_wr_answer: assert property (
    objWrEn |=> objWrAck_r != objWrErr_r) else $error("write answer");
  a_idx_refuse: assert property (
    objWrEn && idxBad |=> objWrErr_r) else $error("bad index taken");
  a_rd_answer: assert property (
    objRdEn && !objWrEn |-> ##2 objRdValid_r != objRdErr_r)
    else $error("read answer");
  a_rd_err_zero: assert property (
    objRdErr_r |-> objRdData_r == 16'h0000) else $error("error read data");
  a_dir_range: assert property (
    objWrEn && dirBad |=> objWrErr_r) else $error("direction range");
  a_tune_range: assert property (
    objWrEn && tuneBad |=> objWrErr_r) else $error("tune range");
  a_dir_apply: assert property (
    $changed(movementDir_r) |-> $past(applyEv)) else $error("dir apply");
  a_tune_still: assert property (
    $changed(tuneMode_r) |-> $past(still)) else $error("tune in motion");
  a_enc_map: assert property (
    {encUp_r, encDown_r} == $past(encExp)) else $error("encoder sense");
  a_pos_block: assert property (
    $past(posHit) |-> posBlocked_r) else $error("pos prohibit");
  c_tune: cover property ($changed(tuneMode_r));
  c_dir: cover property ($fell(movementDir_r));
  c_rd_err: cover property (objRdErr_r);
endmodule : spos_sva

// ### testbench/spos_master.sv
// fieldbus master model driving the object port
// assumes the bench calls its tasks in falling-edge steps
`timescale 1ns/1ps
module spos_master (
  input wire logic ref_clk,
  output logic objWrEn,
  output logic objRdEn,
  output logic [15:0] objIndex,
  output logic [15:0] objWrData
);
  // --------
  // request driver
  // --------
  initial begin
    objWrEn = 1'b0;
    objRdEn = 1'b0;
    objIndex = 16'h0000;
    objWrData = 16'h0000;
  end
  task automatic req(input logic w, input logic r, input logic [15:0] i,
      input logic [15:0] d);
    @(negedge ref_clk);
    objWrEn = w;
    objRdEn = r;
    objIndex = i;
    objWrData = d;
  endtask : req
  // released lines flip so a stale request never looks valid
  task automatic idle();
    req(1'b0, 1'b0, ~objIndex, ~objWrData);
  endtask : idle
endmodule : spos_master

// ### testbench/spos_object_store_tb_top.sv
// bench top for the servo parameter object store
// assumes the master model owns the object port
`timescale 1ns/1ps
module spos_object_store_tb_top;
  // --------
  // bench
  // --------
  logic ref_clk, reset_n, objWrEn, objRdEn, preoperationalState, rndOn;
  logic configCmd, ctrlPowerRestart, motorMoving, commandActive;
  logic cmdPos, cmdNeg, posProhibit, negProhibit;
  logic objWrAck_r, objWrErr_r, objRdValid_r, objRdErr_r;
  logic movementDir_r, dirPending_r, tunePending_r, tuneOff_r;
  logic tuneStable_r, tunePosition_r, tuneUnbal_r, tuneFriction_r;
  logic tuneCustom_r, encUp_r, encDown_r, posBlocked_r, negBlocked_r;
  logic [15:0] objIndex, objWrData, objRdData_r, seed, d;
  logic [2:0] tuneMode_r;
  logic [8:0] expTune;
  logic [19:0] expQ[$];
  int errors = 0;
  int totalChecks = 0;
  int cycles = 0;
  wire logic [5:0] tuneDec = {tuneOff_r, tuneStable_r, tunePosition_r,
    tuneUnbal_r, tuneFriction_r, tuneCustom_r};
  wire logic rdAns = objRdValid_r | objRdErr_r;
  wire logic [19:0] obs = {objWrAck_r, objWrErr_r, objRdValid_r, objRdErr_r,
    rdAns ? objRdData_r : 16'h0000};
  spos_object_store #(.ADDR_W(12), .DATA_W(16)) spos_object_store_i (.*);
  spos_master spos_master_i (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction : xs
  task automatic chk(input string n, input logic [19:0] s,
      input logic [19:0] e);
    totalChecks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wrx(input logic [15:0] i, input logic [15:0] v, input ok);
    expQ.push_back({ok, ~ok, 18'h00000});
    spos_master_i.req(1'b1, 1'b0, i, v);
  endtask : wrx
  task automatic rdx(input logic [15:0] i, input logic [15:0] v, input ok);
    expQ.push_back({2'b00, ok, ~ok, ok ? v : 16'h0000});
    spos_master_i.req(1'b0, 1'b1, i, ~objWrData);
    spos_master_i.idle();
  endtask : rdx
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask : pulse
  task automatic giveVerdict();
    if (errors == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : giveVerdict
  // answers are matched in issue order; one queue serves both ports
  always @(negedge ref_clk) begin
    if (obs[19:16] !== 4'h0) begin
      chk("answer", obs, expQ.size() ? expQ.pop_front() : 20'h0);
    end
  end
  always @(negedge ref_clk) begin
    if (rndOn) begin
      seed = xs(seed);
      {cmdPos, cmdNeg, posProhibit, negProhibit} <= seed[3:0];
      {motorMoving, commandActive, preoperationalState} <= seed[6:4];
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      giveVerdict();
    end
  end
  initial begin
    {reset_n, rndOn, configCmd, ctrlPowerRestart} = 4'h0;
    {motorMoving, commandActive, preoperationalState} = 3'h0;
    {cmdPos, cmdNeg, posProhibit, negProhibit} = 4'h0;
    seed = 16'hc4dc;
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    chk("movementDir_r", 20'(movementDir_r), 20'h1);
    chk("tuneMode_r", 20'({tuneMode_r, tuneDec}), 20'h050);
    rdx(16'h3000, 16'h0001, 1'b1);
    commandActive = 1'b1;
    wrx(16'h3002, 16'h0003, 1'b1);
    spos_master_i.idle();
    repeat (3) @(negedge ref_clk);
    chk("tunePending_r", 20'({tuneMode_r, tunePending_r}), 20'h3);
    commandActive = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("tune", 20'({tuneMode_r, tunePending_r, tuneDec}), 20'h184);
    // motion held off while class B objects change
    for (int v = 0; v < 7; v++) begin
      if (v == 5) continue;
      expTune = {v[2:0], v == 0, v == 1, v == 2, v == 3, v == 4, v == 6};
      wrx(16'h3002, 16'(v), 1'b1);
      spos_master_i.idle();
      repeat (3) @(negedge ref_clk);
      chk("tuneMode_r", 20'({tuneMode_r, tuneDec}), 20'(expTune));
    end
    wrx(16'h3002, 16'h0007, 1'b0);
    wrx(16'h3000, 16'h0002, 1'b0);
    wrx(16'h3a00, 16'h0000, 1'b0);
    wrx(16'h2fff, 16'h0000, 1'b0);
    spos_master_i.idle();
    rdx(16'h3002, 16'h0006, 1'b1);
    rdx(16'h4000, 16'h0000, 1'b0);
    rdx(16'h3000, 16'h0001, 1'b1);
    repeat (4) begin
      seed = xs(seed);
      d = xs(seed);
      wrx({8'h31, seed[7:0]}, d, 1'b1);
      spos_master_i.idle();
      rdx({8'h31, seed[7:0]}, d, 1'b1);
    end
    wrx(16'h3999, 16'h5a5a, 1'b1);
    spos_master_i.idle();
    rdx(16'h3999, 16'h5a5a, 1'b1);
    wrx(16'h3326, 16'h0001, 1'b1);
    spos_master_i.idle();
    pulse(ctrlPowerRestart);
    wrx(16'h3000, 16'h0000, 1'b1);
    spos_master_i.idle();
    repeat (2) @(negedge ref_clk);
    chk("dirPending_r", 20'({movementDir_r, dirPending_r}), 20'h3);
    rdx(16'h3000, 16'h0000, 1'b1);
    pulse(ctrlPowerRestart);
    chk("dirPending_r", 20'({movementDir_r, dirPending_r}), 20'h0);
    {cmdPos, cmdNeg, posProhibit, negProhibit} = 4'h8;
    @(negedge ref_clk);
    chk("encDown_r", 20'({encUp_r, encDown_r}), 20'h1);
    rndOn = 1'b1;
    repeat (300) @(negedge ref_clk);
    rndOn = 1'b0;
    @(negedge ref_clk);
    {motorMoving, commandActive} = 2'b00;
    wrx(16'h3000, 16'h0001, 1'b1);
    spos_master_i.idle();
    pulse(configCmd);
    chk("movementDir_r", 20'(movementDir_r), 20'h1);
    {cmdPos, cmdNeg, posProhibit, negProhibit} = 4'ha;
    @(negedge ref_clk);
    chk("posBlocked_r", 20'({posBlocked_r, encUp_r, encDown_r}), 20'h4);
    {cmdPos, cmdNeg, posProhibit, negProhibit} = 4'h5;
    @(negedge ref_clk);
    chk("negBlocked_r", 20'({negBlocked_r, encUp_r, encDown_r}), 20'h4);
    {cmdPos, cmdNeg, posProhibit, negProhibit} = 4'h8;
    @(negedge ref_clk);
    chk("encUp_r", 20'({posBlocked_r, encUp_r, encDown_r}), 20'h2);
    repeat (4) @(negedge ref_clk);
    chk("queue", 20'(expQ.size()), 20'h0);
    giveVerdict();
  end
endmodule : spos_object_store_tb_top
bind spos_object_store spos_sva #(.DATA_W(DATA_W)) spos_sva_i (.*);
